// *** design/rosl_pin_select.sv ***
/*
  Remappable pin select with run-time lock: 48 output select registers,
  16 input select registers, a lock bit, a one-shot lock configuration
  captured after reset, sticky status and a blocked-write counter, all
  behind an APB slave.
  Assumes a system unlock sequence elsewhere reports its state on
  unlock_ok_i, and that the configuration word is stable at reset.
*/
// Functional notes
// R1 - Locked: select writes ignored, bus completes OK
// R2 - Lock bit is bit 13 of config
// R3 - Lock changes only after system unlock
// R4 - One-shot config forbids clearing a set lock
// R5 - Only reset clears a one-shot lock
// R6 - One-shot config defaults to set
// R7 - 4-bit field per pin, zero disconnects
// R8 - First group code table
// R9 - Second group code table
// R10 - Third group code table
// R11 - Fourth group code table
// R12 - Output selects reset to zero
// R13 - Per-input 4-bit field chooses source pin
// R14 - Reserved or absent code drives nothing
// R15 - New routing applies one clock after write
`timescale 1ns/100ps
module rosl_pin_select (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic unlock_ok_i,
  input wire logic [31:0] device_cfg3_i,
  input wire logic [rosl_pkg::PERIPH_N-1:0] periph_out_i,
  input wire logic [rosl_pkg::PERIPH_N-1:0] periph_avail_i,
  input wire logic [rosl_pkg::OSEL_N-1:0] pin_in_i,
  output logic [rosl_pkg::OSEL_N-1:0] pin_out_o,
  output logic [rosl_pkg::OSEL_N-1:0] pin_oe_n_o,
  output logic [rosl_pkg::ISEL_N-1:0] in_route_o,
  output logic pin_map_lock_o
);
  import rosl_pkg::*;

  // Register state
  logic [OSEL_N-1:0][3:0] osel_ff;
  logic [ISEL_N-1:0][3:0] isel_ff;
  logic lock_ff;
  logic oneshot_ff;
  logic loaded_ff;
  logic blocked_ff;
  logic refused_ff;
  logic [7:0] cnt_ff;
  logic [31:0] prdata_ff;
  logic [ISEL_N-1:0] in_route_ff;

  // Next values
  logic nxt_lock;
  logic nxt_blocked;
  logic nxt_refused;
  logic [7:0] nxt_cnt;
  logic [31:0] nxt_prdata;

  // APB phases
  wire setup = psel_i & ~penable_i;
  wire access = psel_i & penable_i;
  wire wr = access & pwrite_i;
  wire rd_setup = setup & ~pwrite_i;

  // Address decode
  wire [3:0] blk = paddr_i[11:8];
  wire [5:0] widx = paddr_i[7:2];
  wire aligned = (paddr_i[1:0] == 2'b00);
  wire is_cfg = (paddr_i == CFG_OFF);
  wire is_dcw = (paddr_i == DCW3_OFF);
  wire is_sts = (paddr_i == STS_OFF);
  wire is_cnt = (paddr_i == CNT_OFF);
  wire is_osel = aligned && (blk == OSEL_BLK)
    && (widx < 6'(OSEL_N));
  wire is_isel = aligned && (blk == ISEL_BLK)
    && (widx < 6'(ISEL_N));
  wire is_sel = is_osel | is_isel;
  wire mapped = is_cfg | is_dcw | is_sts | is_cnt | is_sel;

  // Byte lanes: select fields in lane 0, lock bit in lane 1
  wire lane0 = pstrb_i[0];
  wire lane1 = pstrb_i[1];

  // Select write is taken only while unlocked; a locked one is dropped
  wire sel_wr = wr && is_sel && lane0;
  wire sel_take = sel_wr && !lock_ff; // R1
  wire sel_drop = sel_wr && lock_ff; // R1
  wire osel_we = sel_take && is_osel;
  wire isel_we = sel_take && is_isel;
  wire [5:0] osel_idx = widx;
  wire [3:0] isel_idx = widx[3:0];
  wire [3:0] wr_code = pwdata_i[3:0];

  // Lock write attempt and the reasons it may be refused
  wire lock_wr = wr && is_cfg && lane1;
  wire want_lock = pwdata_i[LOCK_BIT]; // R2
  wire want_clear = lock_wr && lock_ff && !want_lock;
  wire no_unlock = lock_wr && !unlock_ok_i; // R3
  wire one_shot_hold = oneshot_ff && want_clear; // R4
  wire lock_take = lock_wr && unlock_ok_i && !one_shot_hold;
  wire lock_refused = (lock_wr && (want_lock != lock_ff))
    && (no_unlock || one_shot_hold);

  // Status write-one-to-clear masks
  wire sts_wr = wr && is_sts && lane0;
  wire clr_blocked = sts_wr && pwdata_i[STS_BLOCKED_BIT];
  wire clr_refused = sts_wr && pwdata_i[STS_REFUSED_BIT];
  wire cnt_clr = wr && is_cnt && lane0;

  // Lock next state; with one-shot config set, only reset brings back the cleared value
  assign nxt_lock = lock_take ? want_lock : lock_ff; // R4

  // Sticky flags: a new event wins over a clear in the same cycle
  assign nxt_blocked = sel_drop | (blocked_ff & ~clr_blocked);
  assign nxt_refused = lock_refused | (refused_ff & ~clr_refused);

  // Counter saturates rather than wraps, so a storm stays visible
  wire cnt_inc = sel_drop && (cnt_ff != CNT_MAX);
  wire [7:0] cnt_plus = cnt_ff + 8'h01;
  assign nxt_cnt = cnt_inc ? cnt_plus
    : (cnt_clr ? CNT_RST : cnt_ff);

  // Read data words
  wire [31:0] cfg_word = 32'(lock_ff) << LOCK_BIT;
  wire [31:0] dcw_word = 32'(oneshot_ff) << ONESHOT_BIT;
  wire [31:0] sts_word = (32'(blocked_ff) << STS_BLOCKED_BIT)
    | (32'(refused_ff) << STS_REFUSED_BIT)
    | (32'(loaded_ff) << STS_LOADED_BIT);
  wire [31:0] cnt_word = {24'h000000, cnt_ff};
  wire [31:0] osel_word = {28'h0000000, osel_ff[osel_idx]};
  wire [31:0] isel_word = {28'h0000000, isel_ff[isel_idx]};

  // Read mux; unmapped reads return zero
  assign nxt_prdata = is_cfg ? cfg_word
    : is_dcw ? dcw_word
    : is_sts ? sts_word
    : is_cnt ? cnt_word
    : is_osel ? osel_word
    : is_isel ? isel_word
    : 32'h00000000;

  // Slave answers in the first access cycle; locked writes still OK
  assign pready_o = 1'b1;
  assign pslverr_o = access & ~mapped; // R1
  assign prdata_o = prdata_ff;
  assign pin_map_lock_o = lock_ff;
  assign in_route_o = in_route_ff;

  // Read data captured in the setup cycle, valid through access
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      prdata_ff <= 32'h00000000;
    end else if (rd_setup) begin
      prdata_ff <= nxt_prdata;
    end
  end

  // Lock bit; reset is the only way out of a one-shot lock
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      lock_ff <= LOCK_RST; // R5
    end else begin
      lock_ff <= nxt_lock; // R2
    end
  end

  // One-shot configuration: reads as set until the word is captured
  // on the first clock after reset release
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      oneshot_ff <= ONESHOT_RST; // R6
      loaded_ff <= 1'b0;
    end else if (!loaded_ff) begin
      oneshot_ff <= device_cfg3_i[ONESHOT_BIT];
      loaded_ff <= 1'b1;
    end
  end

  // Status flags and blocked-write counter
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      blocked_ff <= 1'b0;
      refused_ff <= 1'b0;
      cnt_ff <= CNT_RST;
    end else begin
      blocked_ff <= nxt_blocked;
      refused_ff <= nxt_refused;
      cnt_ff <= nxt_cnt;
    end
  end

  // Output select fields, one per remappable pin
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      osel_ff <= {OSEL_N{SEL_RST}}; // R12
    end else if (osel_we) begin
      osel_ff[osel_idx] <= wr_code; // R1
    end
  end

  // Input select fields, one per peripheral input
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      isel_ff <= {ISEL_N{SEL_RST}};
    end else if (isel_we) begin
      isel_ff[isel_idx] <= wr_code; // R1
    end
  end

  // Flat view of the selects for slicing by group
  wire [OSEL_N*4-1:0] osel_flat = osel_ff;

  // Output routing, one table per pin group
  rosl_group_mux #(
    .NPINS(G1_N),
    .MAP(MAP_G1)
  ) u_grp1 (
    .mclk_i(mclk_i),
    .reset_i(reset_i),
    .sel_i(osel_flat[G1_BASE*4 +: G1_N*4]),
    .periph_i(periph_out_i),
    .avail_i(periph_avail_i),
    .pin_out_o(pin_out_o[G1_BASE +: G1_N]),
    .pin_oe_n_o(pin_oe_n_o[G1_BASE +: G1_N])
  ); // R8

  rosl_group_mux #(
    .NPINS(G2_N),
    .MAP(MAP_G2)
  ) u_grp2 (
    .mclk_i(mclk_i),
    .reset_i(reset_i),
    .sel_i(osel_flat[G2_BASE*4 +: G2_N*4]),
    .periph_i(periph_out_i),
    .avail_i(periph_avail_i),
    .pin_out_o(pin_out_o[G2_BASE +: G2_N]),
    .pin_oe_n_o(pin_oe_n_o[G2_BASE +: G2_N])
  ); // R9

  rosl_group_mux #(
    .NPINS(G3_N),
    .MAP(MAP_G3)
  ) u_grp3 (
    .mclk_i(mclk_i),
    .reset_i(reset_i),
    .sel_i(osel_flat[G3_BASE*4 +: G3_N*4]),
    .periph_i(periph_out_i),
    .avail_i(periph_avail_i),
    .pin_out_o(pin_out_o[G3_BASE +: G3_N]),
    .pin_oe_n_o(pin_oe_n_o[G3_BASE +: G3_N])
  ); // R10

  rosl_group_mux #(
    .NPINS(G4_N),
    .MAP(MAP_G4)
  ) u_grp4 (
    .mclk_i(mclk_i),
    .reset_i(reset_i),
    .sel_i(osel_flat[G4_BASE*4 +: G4_N*4]),
    .periph_i(periph_out_i),
    .avail_i(periph_avail_i),
    .pin_out_o(pin_out_o[G4_BASE +: G4_N]),
    .pin_oe_n_o(pin_oe_n_o[G4_BASE +: G4_N])
  ); // R11

  // Input routing: inputs 0-3 draw on group 1, 4-7 on group 2, and so
  // on; a code past the group size feeds a constant low
  logic [ISEL_N-1:0] nxt_route;

  genvar j;
  generate
    for (j = 0; j < ISEL_N; j++) begin : g_in
      localparam int GI = j / 4;
      localparam int GB = (GI == 0) ? G1_BASE
        : (GI == 1) ? G2_BASE
        : (GI == 2) ? G3_BASE : G4_BASE;
      localparam int GN = (GI == 0) ? G1_N
        : (GI == 1) ? G2_N
        : (GI == 2) ? G3_N : G4_N;
      wire [3:0] code = isel_ff[j];
      wire ok = (code < 4'(GN));
      wire [5:0] pin = 6'(GB) + {2'b00, code};
      assign nxt_route[j] = ok ? pin_in_i[pin] : 1'b0; // R13
    end
  endgenerate

  // Registered so a select change cannot glitch the peripheral input
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      in_route_ff <= '0;
    end else begin
      in_route_ff <= nxt_route; // R13
    end
  end

endmodule

// *** common/rosl_pkg.sv ***
/*
  Constants and types shared by the remappable pin select block: register
  offsets, field positions, reset values, peripheral output indices and
  the code-to-peripheral table of each pin group.
  Assumes a 12-bit APB byte address window and one word per register.
*/
package rosl_pkg;

  // Register map, byte addresses
  localparam logic [11:0] CFG_OFF = 12'h000;
  localparam logic [11:0] DCW3_OFF = 12'h004;
  localparam logic [11:0] STS_OFF = 12'h008;
  localparam logic [11:0] CNT_OFF = 12'h00C;
  localparam logic [3:0] OSEL_BLK = 4'h1;
  localparam logic [3:0] ISEL_BLK = 4'h2;

  // Field positions
  localparam int LOCK_BIT = 13;
  localparam int ONESHOT_BIT = 29;
  localparam int STS_BLOCKED_BIT = 0;
  localparam int STS_REFUSED_BIT = 1;
  localparam int STS_LOADED_BIT = 2;

  // Values after reset
  localparam logic LOCK_RST = 1'b0;
  localparam logic ONESHOT_RST = 1'b1;
  localparam logic [3:0] SEL_RST = 4'h0;
  localparam logic [7:0] CNT_RST = 8'h00;
  localparam logic [7:0] CNT_MAX = 8'hFF;

  // Sizes
  localparam int SEL_W = 4;
  localparam int OSEL_N = 48;
  localparam int ISEL_N = 16;
  localparam int GRP_N = 4;
  localparam int PERIPH_N = 27;
  localparam int G1_BASE = 0;
  localparam int G1_N = 13;
  localparam int G2_BASE = 13;
  localparam int G2_N = 14;
  localparam int G3_BASE = 27;
  localparam int G3_N = 14;
  localparam int G4_BASE = 41;
  localparam int G4_N = 7;

  // Peripheral output indices into the periph_out_i vector
  localparam logic [4:0] P_UART3_TX = 5'h00;
  localparam logic [4:0] P_UART4_RTS = 5'h01;
  localparam logic [4:0] P_SPI2_DO = 5'h02;
  localparam logic [4:0] P_CMP3_OUT = 5'h03;
  localparam logic [4:0] P_CAN1_TX = 5'h04;
  localparam logic [4:0] P_ACMP2_OUT = 5'h05;
  localparam logic [4:0] P_SPI3_DO = 5'h06;
  localparam logic [4:0] P_SPI4_DO = 5'h07;
  localparam logic [4:0] P_UART2_TX = 5'h08;
  localparam logic [4:0] P_UART1_TX = 5'h09;
  localparam logic [4:0] P_UART5_RTS = 5'h0A;
  localparam logic [4:0] P_SPI1_DO = 5'h0B;
  localparam logic [4:0] P_CMP4_OUT = 5'h0C;
  localparam logic [4:0] P_UART3_RTS = 5'h0D;
  localparam logic [4:0] P_UART4_TX = 5'h0E;
  localparam logic [4:0] P_REFCLK_OUT = 5'h0F;
  localparam logic [4:0] P_UART5_TX = 5'h10;
  localparam logic [4:0] P_SPI1_SEL = 5'h11;
  localparam logic [4:0] P_CMP5_OUT = 5'h12;
  localparam logic [4:0] P_ACMP1_OUT = 5'h13;
  localparam logic [4:0] P_SPI3_SEL = 5'h14;
  localparam logic [4:0] P_SPI4_SEL = 5'h15;
  localparam logic [4:0] P_UART2_RTS = 5'h16;
  localparam logic [4:0] P_UART1_RTS = 5'h17;
  localparam logic [4:0] P_SPI2_SEL = 5'h18;
  localparam logic [4:0] P_CMP2_OUT = 5'h19;
  localparam logic [4:0] P_CMP1_OUT = 5'h1A;
  localparam logic [4:0] NC = 5'h1F;

  // Code-to-peripheral table, entry 15 written first
  typedef logic [15:0][4:0] rosl_map_t;

  localparam rosl_map_t MAP_G1 = {P_SPI4_DO, P_SPI3_DO, P_ACMP2_OUT,
    P_CAN1_TX, P_CMP3_OUT, NC, NC, NC, NC, P_SPI2_DO, NC, NC, NC,
    P_UART4_RTS, P_UART3_TX, NC}; // R8
  localparam rosl_map_t MAP_G2 = {P_SPI4_DO, P_SPI3_DO, NC, NC,
    P_CMP4_OUT, NC, NC, P_SPI1_DO, NC, P_SPI2_DO, NC, P_UART5_RTS,
    P_UART1_TX, NC, P_UART2_TX, NC}; // R9
  localparam rosl_map_t MAP_G3 = {P_SPI4_SEL, P_SPI3_SEL, P_ACMP1_OUT,
    NC, P_CMP5_OUT, NC, NC, P_SPI1_DO, P_SPI1_SEL, NC, NC, P_UART5_TX,
    P_REFCLK_OUT, P_UART4_TX, P_UART3_RTS, NC}; // R10
  localparam rosl_map_t MAP_G4 = {NC, NC, NC, P_CMP1_OUT, P_CMP2_OUT,
    NC, NC, P_SPI1_DO, NC, P_SPI2_SEL, NC, P_UART5_TX, P_UART1_RTS, NC,
    P_UART2_RTS, NC}; // R11

endpackage

// *** design/rosl_group_mux.sv ***
/*
  Output multiplexer for one group of remappable pins: decodes each
  pin's 4-bit select code through the group table and registers the
  routed peripheral level and its active-low drive enable.
  Assumes select fields are registered and peripheral outputs are
  synchronous to mclk_i.
*/
`timescale 1ns/100ps
module rosl_group_mux #(
  parameter int NPINS = 13,
  parameter rosl_pkg::rosl_map_t MAP = '0
) (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic [NPINS*4-1:0] sel_i,
  input wire logic [rosl_pkg::PERIPH_N-1:0] periph_i,
  input wire logic [rosl_pkg::PERIPH_N-1:0] avail_i,
  output logic [NPINS-1:0] pin_out_o,
  output logic [NPINS-1:0] pin_oe_n_o
);
  import rosl_pkg::*;

  logic [NPINS-1:0] nxt_out;
  logic [NPINS-1:0] nxt_oe_n;

  genvar p;
  generate
    for (p = 0; p < NPINS; p++) begin : g_pin
      wire [4:0] idx = MAP[sel_i[p*4 +: 4]];
      // Reserved or absent peripherals behave as no connection
      wire in_rng = (idx < 5'(PERIPH_N));
      wire hit = in_rng && avail_i[idx[4:0]]; // R14
      assign nxt_out[p] = hit ? periph_i[idx[4:0]] : 1'b0; // R7
      assign nxt_oe_n[p] = ~hit;
    end
  endgenerate

  // Registered so a routing change never glitches a neighbour pin
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      pin_out_o <= '0;
      pin_oe_n_o <= '1;
    end else begin
      pin_out_o <= nxt_out; // R15
      pin_oe_n_o <= nxt_oe_n;
    end
  end

endmodule

// *** verif/rosl_pin_select_checker.sv ***
/*
  Concurrent checks on the remappable pin select top: bus answer, lock
  handling, dropped writes while locked, routing latency, reset state.
  Assumes device_cfg3_i stays constant for the whole run.
*/
`timescale 1ns/100ps
module rosl_pin_select_checker
  import rosl_pkg::*;
(
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic unlock_ok_i,
  input wire logic [31:0] device_cfg3_i,
  input wire logic [PERIPH_N-1:0] periph_avail_i,
  input wire logic [OSEL_N-1:0] pin_out_o,
  input wire logic [OSEL_N-1:0] pin_oe_n_o,
  input wire logic pin_map_lock_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (reset_i);

  // Transfer decode shared by the properties
  wire logic acc_wr = psel_i && penable_i && pwrite_i;
  wire logic osel_hit = paddr_i[11:8] == OSEL_BLK;
  wire logic osel_ok = osel_hit && paddr_i[7:0] < 8'hC0
    && paddr_i[1:0] == 2'h0;

  sequence locked_wr;
    acc_wr && osel_hit && pin_map_lock_o;
  endsequence
  sequence open_nc_wr;
    acc_wr && paddr_i == 12'h100 && pstrb_i[0] && !pin_map_lock_o &&
      pwdata_i[3:0] == 4'h0;
  endsequence

  AST_READY_ALWAYS: assert property (psel_i |-> pready_o)
    else $error("pready low during a transfer");
  AST_NO_ERR_OSEL: assert property (psel_i && penable_i && osel_ok
    |-> !pslverr_o)
    else $error("error answer on a select register");
  // Oe depends only on select and availability, so it must not move
  AST_LOCKED_DROP: assert property (locked_wr
    ##1 $stable(periph_avail_i) |=> $stable(pin_oe_n_o))
    else $error("locked select write changed routing");
  AST_LOCK_SET: assert property (acc_wr && paddr_i == CFG_OFF && pstrb_i[1] &&
    unlock_ok_i && pwdata_i[LOCK_BIT] |=> pin_map_lock_o)
    else $error("lock not set by an unlocked write");
  AST_LOCK_NEEDS_UNLOCK: assert property (!unlock_ok_i |=> $stable(pin_map_lock_o))
    else $error("lock moved without unlock");
  AST_ONESHOT_STICKY: assert property (pin_map_lock_o
    && device_cfg3_i[ONESHOT_BIT] |=> pin_map_lock_o)
    else $error("one-shot lock cleared without reset");
  AST_NC_LATENCY: assert property (open_nc_wr |=> ##1 pin_oe_n_o[0] && !pin_out_o[0])
    else $error("no-connect code not applied one clock after write");
  AST_RESET_DISCONNECT: assert property ($fell(reset_i) |-> &pin_oe_n_o &&
    pin_out_o == '0 && !pin_map_lock_o)
    else $error("pins or lock not cleared by reset");
endmodule

bind rosl_pin_select rosl_pin_select_checker rosl_pin_select_checker_inst (
  .mclk_i, .reset_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
  .pstrb_i, .pready_o, .pslverr_o, .unlock_ok_i, .device_cfg3_i,
  .periph_avail_i, .pin_out_o, .pin_oe_n_o, .pin_map_lock_o
);

// *** verif/tb.sv ***
/*
  Self-checking bench for the remappable pin select block: APB access
  task, code tables of all four groups, input routing, lock and reset.
  Assumes the zero-wait-state APB answer described for the block.
*/
`timescale 1ns/100ps
module tb;
  import rosl_pkg::*;
  localparam rosl_map_t MAPS [4] = '{MAP_G1, MAP_G2, MAP_G3, MAP_G4};
  localparam int BASES [4] = '{0, 13, 27, 41};
  localparam logic [11:0] OSEL0 = {OSEL_BLK, 8'h00};
  localparam logic [11:0] ISEL0 = {ISEL_BLK, 8'h00};
  logic mclk_i = 1'b0;
  logic reset_i = 1'b1;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0;
  logic [3:0] pstrb_i = 4'h0;
  logic unlock_ok_i = 1'b0;
  logic [31:0] device_cfg3_i = 32'h2000_0000;
  logic [PERIPH_N-1:0] periph_out_i = '0;
  logic [PERIPH_N-1:0] periph_avail_i = ~(27'h1 << P_SPI4_DO);
  logic [OSEL_N-1:0] pin_in_i = '0;
  logic [31:0] prdata_o;
  logic pready_o;
  logic pslverr_o;
  logic [OSEL_N-1:0] pin_out_o;
  logic [OSEL_N-1:0] pin_oe_n_o;
  logic [ISEL_N-1:0] in_route_o;
  logic pin_map_lock_o;
  logic [31:0] rd;
  logic er;
  logic [4:0] idx;
  logic drv;
  int mismatches = 0;
  int n_tests = 0;

  rosl_pin_select rosl_pin_select_inst (.mclk_i, .reset_i, .psel_i,
    .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pstrb_i, .prdata_o,
    .pready_o, .pslverr_o, .unlock_ok_i, .device_cfg3_i, .periph_out_i,
    .periph_avail_i, .pin_in_i, .pin_out_o, .pin_oe_n_o, .in_route_o,
    .pin_map_lock_o);

  // 200 MHz clock
  initial begin
    forever #2.5 mclk_i = ~mclk_i;
  end

  // One APB transfer; request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, input logic [3:0] s);
    int k;
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    pstrb_i <= s;
    @(posedge mclk_i);
    penable_i <= 1'b1;
    k = 0;
    do begin
      @(posedge mclk_i);
      k++;
    end while (pready_o !== 1'b1 && k < 50);
    if (pready_o !== 1'b1)
      mismatches++;
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    // Idle edge so a following call never reassigns psel in this step
    @(posedge mclk_i);
  endtask

  // Wait for one more edge so registered outputs settle
  task automatic settle;
    @(posedge mclk_i);
    #1;
  endtask

  task automatic chk(input string nm, input logic [47:0] e,
                     input logic [47:0] g);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  task automatic do_reset;
    reset_i <= 1'b1;
    repeat (20) @(posedge mclk_i);
    reset_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
  endtask

  task automatic end_sim;
    $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Cuts a hang short, far beyond the roughly 550 cycles needed
  initial begin
    repeat (20000) @(posedge mclk_i);
    mismatches++;
    end_sim();
  end

  initial begin
    do_reset();
    #1;
    chk("oe_n after reset", '1, pin_oe_n_o);
    chk("out after reset", '0, pin_out_o);
    apb(1'b0, DCW3_OFF, 32'h0, 4'h0);
    chk("one-shot cfg", 1'b1, rd[ONESHOT_BIT]);
    // Lock request without the system unlock must be refused
    apb(1'b1, CFG_OFF, 32'h0000_2000, 4'h2);
    settle();
    chk("lock w/o unlock", 1'b0, pin_map_lock_o);
    // Every code of every group on the group's first pin
    for (int g = 0; g < 4; g++) begin
      for (int c = 0; c < 16; c++) begin
        idx = MAPS[g][c];
        drv = (idx != NC) && periph_avail_i[idx];
        periph_out_i <= {PERIPH_N{c[0]}};
        apb(1'b1, OSEL0 + 12'(4 * BASES[g]), 32'(c), 4'h1);
        settle();
        chk("pin oe_n", !drv, pin_oe_n_o[BASES[g]]);
        chk("pin out", drv && c[0], pin_out_o[BASES[g]]);
        apb(1'b0, OSEL0 + 12'(4 * BASES[g]), 32'h0, 4'h0);
        chk("osel readback", 32'(c), rd);
      end
    end
    // Input 0 takes group 1 pin 2
    apb(1'b1, ISEL0, 32'h2, 4'h1);
    pin_in_i <= 48'h4;
    settle();
    settle();
    chk("in route high", 1'b1, in_route_o[0]);
    pin_in_i <= 48'h0;
    settle();
    settle();
    chk("in route low", 1'b0, in_route_o[0]);
    // Lock, then try to rewrite selects
    unlock_ok_i <= 1'b1;
    apb(1'b1, CFG_OFF, 32'h0000_2000, 4'h2);
    apb(1'b0, CFG_OFF, 32'h0, 4'h0);
    chk("lock bit", 1'b1, rd[LOCK_BIT]);
    apb(1'b1, OSEL0 + 12'd108, 32'h0, 4'h1);
    chk("locked write err", 1'b0, er);
    apb(1'b1, ISEL0, 32'h5, 4'h1);
    settle();
    chk("locked pin oe_n", 1'b0, pin_oe_n_o[27]);
    apb(1'b0, OSEL0 + 12'd108, 32'h0, 4'h0);
    chk("locked osel", 32'hF, rd);
    apb(1'b0, ISEL0, 32'h0, 4'h0);
    chk("locked isel", 32'h2, rd);
    // One-shot: clearing a set lock is refused
    apb(1'b1, CFG_OFF, 32'h0, 4'h2);
    settle();
    chk("lock kept", 1'b1, pin_map_lock_o);
    // Two dropped select writes, refused lock moves, config loaded
    apb(1'b0, STS_OFF, 32'h0, 4'h0);
    chk("status", 32'h7, rd);
    apb(1'b0, CNT_OFF, 32'h0, 4'h0);
    chk("blocked count", 32'h2, rd);
    // Only reset frees the selects again
    do_reset();
    #1;
    chk("lock after reset", 1'b0, pin_map_lock_o);
    apb(1'b0, OSEL0 + 12'd108, 32'h0, 4'h0);
    chk("osel after reset", 32'h0, rd);
    apb(1'b1, OSEL0 + 12'd108, 32'hF, 4'h1);
    apb(1'b0, OSEL0 + 12'd108, 32'h0, 4'h0);
    chk("osel writable", 32'hF, rd);
    apb(1'b0, 12'hFFC, 32'h0, 4'h0);
    chk("unmapped err", 1'b1, er);
    chk("unmapped data", 32'h0, rd);
    end_sim();
  end
endmodule
